// ---- logic/ric_cause_if.sv ----
// Purpose: Synchronised halt-watchdog cause and wait length carried to the wait counter.
// Assumes: All signals on clk.
// Notes:   Built by the top module, read by the wait counter.
`timescale 1ns/1ps
`default_nettype none
interface ric_cause_if;
  logic        start;
  logic [10:0] cycles;
  logic        busy;
  modport src (output start, output cycles, input busy);
  modport cnt (input start, input cycles, output busy);
endinterface
`default_nettype wire

// ---- logic/ric_pkg.sv ----
// Purpose: Shared constants for the reset initial-conditions block.
// Assumes: System clock of 40 MHz.
// Notes:   Reset values are the power-on and warm-reset images.
package ric_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned POWER_ON_DELAY_MS = 50;
  localparam int unsigned POWER_ON_DELAY_CYC =
    (CLK_HZ / 1000) * POWER_ON_DELAY_MS;
  localparam logic [10:0] SST_FAST_INT_CYC = 11'h010;
  localparam logic [10:0] SST_CRYSTAL_CYC  = 11'h400;
  localparam logic [10:0] SST_SLOW_INT_CYC = 11'h002;
  localparam logic [1:0]  CLK_FAST_INT = 2'h0;
  localparam logic [1:0]  CLK_CRYSTAL  = 2'h1;
  localparam logic [1:0]  CLK_SLOW_INT = 2'h2;
  localparam logic [7:0]  PORT_RESET   = 8'hFF;
  localparam logic [7:0]  PORT_CTRL_RESET = 8'hFF;
  localparam logic [4:0]  ANALOG_SEL_RESET = 5'h1F;
  localparam logic [7:0]  INT_EN_RESET = 8'h00;
  localparam logic [7:0]  TIMER_CTRL_RESET = 8'h00;
  localparam logic [7:0]  MODE_CTRL_RESET = 8'h03;
  localparam logic [7:0]  LV_SEL_RESET = 8'h55;
  localparam logic [7:0]  WDT_CTRL_RESET = 8'h53;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [2:0]  SP_RESET = 3'h0;
  localparam logic [2:0]  SP_TOP   = 3'h0;
endpackage

// ---- logic/ric_top.sv ----
// Purpose: Reset initial conditions and restart hold-off for a small MCU.
// Assumes: Reset causes are asynchronous pins; they are synchronised here.
// Notes:   Register images go out as init values with a load pulse; warm load lasts while low voltage is held.
// What this block does
// - Halt watchdog timeout clears program counter and stack pointer, sets timeout.
// - Fast internal clock source waits fifteen to sixteen cycles before resuming.
// - Crystal clock source waits 1024 cycles before resuming execution.
// - Slow internal clock source waits one to two cycles before resuming.
// - Flags by cause: power-on clears both, low-voltage keeps, watchdog sets.
// - Power-on reset disables every interrupt source.
// - Power-on reset clears the watchdog counter, which then counts at once.
// - Power-on reset turns off all timer modules.
// - Power-on makes pins inputs and five analog pins converter inputs.
// - Power-on sets the stack pointer to the top of stack.
// - Four reset kinds drive three load pulses over one shared image; halt keeps most.
// - Normal watchdog reset equals low-voltage reset plus timeout flag set.
// - After power-on, internal reset is held for about fifty milliseconds.
`timescale 1ns/1ps
`default_nettype none
module ric_top #(
  parameter int unsigned POR_CYCLES = ric_pkg::POWER_ON_DELAY_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        power_on_reset,
  input  wire logic        low_voltage_reset,
  input  wire logic        wdt_overflow,
  input  wire logic        halted,
  input  wire logic [1:0]  clk_source,
  input  wire logic        flag_clear,
  output logic             core_hold,
  output logic             load_warm,
  output logic             load_halt,
  output logic             load_por,
  output logic             wdt_counter_clear,
  output logic             wdt_run,
  output logic             wdt_timeout_flag,
  output logic             powerdown_flag,
  output logic [12:0]      pc_init,
  output logic [2:0]       sp_init,
  output logic [7:0]       int_en_init,
  output logic [7:0]       timer_ctrl_init,
  output logic [7:0]       port_init,
  output logic [7:0]       port_ctrl_init,
  output logic [4:0]       analog_input_pins,
  output logic [7:0]       mode_ctrl_init,
  output logic [7:0]       lv_sel_init,
  output logic [7:0]       wdt_ctrl_init
);
  typedef enum logic [3:0] {
    RIC_RUN  = 4'h1,
    RIC_POR  = 4'h2,
    RIC_WARM = 4'h4,
    RIC_WAKE = 4'h8
  } ric_state_e;

  ric_state_e state;
  ric_state_e next_state;
  logic [2:0] s_por, s_lvr, s_wdt, s_halt;
  logic [25:0] por_count;
  logic        por_done;
  logic        wdt_prev;
  logic        wdt_event;
  logic        ev_halt_wdt;
  logic        ev_norm_wdt;
  logic        ev_warm;
  ric_cause_if wif ();

  // Two-stage synchronisers; only stage 1 reads stage 0.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_por  <= 3'h7;
      s_lvr  <= 3'h0;
      s_wdt  <= 3'h0;
      s_halt <= 3'h0;
    end else begin
      s_por  <= {s_por[1:0], power_on_reset};
      s_lvr  <= {s_lvr[1:0], low_voltage_reset};
      s_wdt  <= {s_wdt[1:0], wdt_overflow};
      s_halt <= {s_halt[1:0], halted};
    end
  end

  // Cause decode; power-on dominates every warm cause.
  assign wdt_event   = s_wdt[1] & ~wdt_prev;
  assign ev_halt_wdt = wdt_event & s_halt[1] & ~s_por[1];
  assign ev_norm_wdt = wdt_event & ~s_halt[1] & ~s_por[1];
  assign ev_warm     = (s_lvr[1] | ev_norm_wdt) & ~s_por[1];
  assign por_done    = (por_count == 26'(POR_CYCLES - 1));

  // Edge memory for the watchdog overflow strobe.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wdt_prev <= 1'b0;
    end else begin
      wdt_prev <= s_wdt[1];
    end
  end

  // Power-on delay counter runs only in RIC_POR after power-on drops.
  always_ff @(posedge clk) begin
    if (!resetn || s_por[1] || state != RIC_POR) begin
      por_count <= 26'h0000000;
    end else if (!por_done) begin
      por_count <= por_count + 26'h0000001;
    end
  end

  // Wake wait length follows the selected system clock source.
  always_comb begin
    wif.cycles = ric_pkg::SST_FAST_INT_CYC;
    if (clk_source == ric_pkg::CLK_CRYSTAL) begin
      wif.cycles = ric_pkg::SST_CRYSTAL_CYC;
    end else if (clk_source == ric_pkg::CLK_SLOW_INT) begin
      wif.cycles = ric_pkg::SST_SLOW_INT_CYC;
    end
  end
  assign wif.start = ev_halt_wdt;

  ric_wait u_wait (
    .clk    (clk),
    .resetn (resetn),
    .w      (wif)
  );

  // Sequencer: power-on wins, then warm causes, then halt wake.
  always_comb begin
    next_state = state;
    unique case (state)
      RIC_POR: begin
        if (!s_por[1] && por_done) begin
          next_state = RIC_RUN;
        end
      end
      RIC_WARM: begin
        next_state = RIC_RUN;
      end
      RIC_WAKE: begin
        if (!wif.busy) begin
          next_state = RIC_RUN;
        end
      end
      RIC_RUN: begin
        next_state = RIC_RUN;
      end
      default: begin
        next_state = RIC_POR;
      end
    endcase
    if (s_por[1]) begin
      next_state = RIC_POR;
    end else if (ev_warm) begin
      next_state = RIC_WARM;
    end else if (ev_halt_wdt) begin
      next_state = RIC_WAKE;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= RIC_POR;
    end else begin
      state <= next_state;
    end
  end

  // Core is held through power-on delay, warm reset and wake wait.
  assign core_hold = (state != RIC_RUN) || ev_warm || ev_halt_wdt || s_por[1];

  // Load pulses per reset kind; power-on and halt last one cycle, warm lasts while low voltage is held.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      load_por  <= 1'b0;
      load_warm <= 1'b0;
      load_halt <= 1'b0;
    end else begin
      load_por  <= s_por[1] & ~s_por[2];
      load_warm <= ev_warm;
      load_halt <= ev_halt_wdt;
    end
  end

  // Watchdog cleared during power-on and warm resets; runs when released.
  assign wdt_counter_clear = (state == RIC_POR) || (state == RIC_WARM);
  assign wdt_run = ~wdt_counter_clear;

  // Status flags by cause; power-on and watchdog events win over a software clear.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wdt_timeout_flag <= 1'b0;
      powerdown_flag   <= 1'b0;
    end else if (s_por[1]) begin
      wdt_timeout_flag <= 1'b0;
      powerdown_flag   <= 1'b0;
    end else if (ev_halt_wdt) begin
      wdt_timeout_flag <= 1'b1;
      powerdown_flag   <= 1'b1;
    end else if (ev_norm_wdt) begin
      wdt_timeout_flag <= 1'b1;
    end else if (flag_clear) begin
      wdt_timeout_flag <= 1'b0;
      powerdown_flag   <= 1'b0;
    end
  end

  // Initial-value images; constant, sampled by the core on a load pulse.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_init           <= ric_pkg::PC_RESET;
      sp_init           <= ric_pkg::SP_RESET;
      int_en_init       <= ric_pkg::INT_EN_RESET;
      timer_ctrl_init   <= ric_pkg::TIMER_CTRL_RESET;
      port_init         <= ric_pkg::PORT_RESET;
      port_ctrl_init    <= ric_pkg::PORT_CTRL_RESET;
      analog_input_pins <= ric_pkg::ANALOG_SEL_RESET;
      mode_ctrl_init    <= ric_pkg::MODE_CTRL_RESET;
      lv_sel_init       <= ric_pkg::LV_SEL_RESET;
      wdt_ctrl_init     <= ric_pkg::WDT_CTRL_RESET;
    end else begin
      pc_init           <= ric_pkg::PC_RESET;
      sp_init           <= ric_pkg::SP_TOP;
      int_en_init       <= ric_pkg::INT_EN_RESET;
      timer_ctrl_init   <= ric_pkg::TIMER_CTRL_RESET;
      port_init         <= ric_pkg::PORT_RESET;
      port_ctrl_init    <= ric_pkg::PORT_CTRL_RESET;
      analog_input_pins <= ric_pkg::ANALOG_SEL_RESET;
      mode_ctrl_init    <= ric_pkg::MODE_CTRL_RESET;
      lv_sel_init       <= ric_pkg::LV_SEL_RESET;
      wdt_ctrl_init     <= ric_pkg::WDT_CTRL_RESET;
    end
  end
endmodule
`default_nettype wire

// ---- logic/ric_wait.sv ----
// Purpose: Counts a stabilisation wait in system clock cycles.
// Assumes: start is a one-cycle pulse; cycles at least one.
// Notes:   A new start while busy restarts the count.
`timescale 1ns/1ps
`default_nettype none
module ric_wait (
  input  wire logic clk,
  input  wire logic resetn,
  ric_cause_if.cnt  w
);
  logic [10:0] count;

  // Busy is high for exactly the programmed number of cycles.
  assign w.busy = (count != 11'h000);

  // Load on start, then count down to zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= 11'h000;
    end else if (w.start) begin
      count <= w.cycles;
    end else if (count != 11'h000) begin
      count <= count - 11'h001;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/ric_checker.sv ----
// Purpose: Port assertions for ric_top.
// Assumes: One clock, synchronous reset.
// Notes:   Bound into every ric_top below.
`timescale 1ns/1ps
`default_nettype none
module ric_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        power_on_reset,
  input wire logic        core_hold,
  input wire logic        load_warm,
  input wire logic        load_halt,
  input wire logic        load_por,
  input wire logic        wdt_run,
  input wire logic        wdt_timeout_flag,
  input wire logic        powerdown_flag,
  input wire logic [12:0] pc_init,
  input wire logic [2:0]  sp_init,
  input wire logic [7:0]  int_en_init,
  input wire logic [7:0]  timer_ctrl_init,
  input wire logic [7:0]  port_ctrl_init,
  input wire logic [4:0]  analog_input_pins
);
  // One domain, so clock and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_halt; load_halt |-> wdt_timeout_flag && powerdown_flag
    && pc_init == 13'h0000 && sp_init == 3'h0; endproperty
  a_halt: assert property (p_halt) else $error("halt load bad");
  property p_porf; load_por |-> !wdt_timeout_flag && !powerdown_flag;
  endproperty
  a_porf: assert property (p_porf) else $error("por flags bad");
  property p_warm; load_warm |-> $stable(powerdown_flag); endproperty
  a_warm: assert property (p_warm) else $error("warm flag bad");
  property p_init; load_por |-> int_en_init == 8'h00 && sp_init == 3'h0
    && timer_ctrl_init == 8'h00 && port_ctrl_init == 8'hFF
    && analog_input_pins == 5'h1F; endproperty
  a_init: assert property (p_init)
    else $error("por image bad");
  property p_one; $onehot0({load_por, load_warm, load_halt}); endproperty
  a_one: assert property (p_one) else $error("two loads");
  property p_sst; load_halt |-> core_hold [*2]; endproperty
  a_sst: assert property (p_sst) else $error("wake short");
  property p_hold; power_on_reset [*4] |-> core_hold; endproperty
  a_hold: assert property (p_hold) else $error("por not held");
  property p_run; !core_hold |-> wdt_run; endproperty
  a_run: assert property (p_run) else $error("wdt stopped");
endmodule
bind ric_top ric_checker u_chk (.clk, .resetn, .power_on_reset,
  .core_hold, .load_warm, .load_halt, .load_por, .wdt_run,
  .wdt_timeout_flag, .powerdown_flag, .pc_init, .sp_init, .int_en_init,
  .timer_ctrl_init, .port_ctrl_init, .analog_input_pins);
`default_nettype wire

// ---- testbench/ric_core_model.sv ----
// Purpose: Core that takes the reset images.
// Assumes: Power-on and halt loads are one-cycle pulses.
// Notes:   Only four registers are kept.
`timescale 1ns/1ps
`default_nettype none
module ric_core_model (
  input  wire logic        clk,
  input  wire logic        core_hold,
  input  wire logic        load_por,
  input  wire logic        load_warm,
  input  wire logic        load_halt,
  input  wire logic [12:0] pc_init,
  input  wire logic [2:0]  sp_init,
  input  wire logic [7:0]  int_en_init,
  input  wire logic [7:0]  port_ctrl_init,
  input  wire logic        wr,
  input  wire logic [7:0]  wr_val,
  output logic      [12:0] pc,
  output logic      [2:0]  sp,
  output logic      [7:0]  int_en,
  output logic      [7:0]  port_ctrl
);
  // A halt wake keeps all but the counters, so stale state shows.
  always_ff @(posedge clk) begin
    if (load_por || load_warm) begin
      {pc, sp, int_en, port_ctrl} <= {pc_init, sp_init, int_en_init,
        port_ctrl_init};
    end else if (load_halt) begin
      {pc, sp} <= {pc_init, sp_init};
    end else begin
      if (!core_hold) pc <= pc + 13'h0001;
      if (wr) int_en <= wr_val;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for ric_top.
// Assumes: POR_CYCLES shortened to 20.
// Notes:   Inputs change by NBA on rising edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned PORC = 20;
  logic clk = 1'b0, resetn = 1'b0, power_on_reset = 1'b1;
  logic low_voltage_reset = 1'b0, wdt_overflow = 1'b0, halted = 1'b0;
  logic [1:0] clk_source = 2'h0;
  logic flag_clear = 1'b0, wr = 1'b0;
  logic [7:0] wr_val = 8'h00;
  logic core_hold, load_warm, load_halt, load_por, wdt_run;
  logic wdt_counter_clear;
  logic wdt_timeout_flag, powerdown_flag;
  logic [12:0] pc_init, pc;
  logic [2:0] sp_init, sp;
  logic [7:0] int_en_init, timer_ctrl_init, port_init, port_ctrl_init;
  logic [7:0] mode_ctrl_init, lv_sel_init, wdt_ctrl_init, int_en, port_ctrl;
  logic [4:0] analog_input_pins;
  int failures = 0, cmp_count = 0;
  // Free-running system clock.
  always #12.5 clk = ~clk;
  ric_top #(.POR_CYCLES(PORC)) dut (.clk, .resetn, .power_on_reset,
    .low_voltage_reset, .wdt_overflow, .halted, .clk_source, .flag_clear,
    .core_hold, .load_warm, .load_halt, .load_por, .wdt_counter_clear,
    .wdt_run, .wdt_timeout_flag, .powerdown_flag, .pc_init, .sp_init,
    .int_en_init, .timer_ctrl_init, .port_init, .port_ctrl_init,
    .analog_input_pins, .mode_ctrl_init, .lv_sel_init, .wdt_ctrl_init);
  ric_core_model core (.clk, .core_hold, .load_por, .load_warm, .load_halt,
    .pc_init, .sp_init, .int_en_init, .port_ctrl_init, .wr, .wr_val, .pc,
    .sp, .int_en, .port_ctrl);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [39:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Counts hold cycles; the bound keeps a stuck hold from hanging.
  task automatic hold_n(output int n);
    n = 0;
    while (core_hold === 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic core_wr(input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    wr_val <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic t_norm();
    int n;
    core_wr(8'hA5);
    flag_clear <= 1'b1;
    @(posedge clk);
    flag_clear <= 1'b0;
    wdt_overflow <= 1'b1;
    repeat (5) @(posedge clk);
    wdt_overflow <= 1'b0;
    hold_n(n);
    chk("flg_n", 2'h2, {wdt_timeout_flag, powerdown_flag});
    chk("ie_n", 8'h00, int_en);
  endtask
  task automatic t_halt(input logic [1:0] s, input int w);
    int n;
    core_wr(8'hA5);
    clk_source <= s;
    halted <= 1'b1;
    repeat (3) @(posedge clk);
    wdt_overflow <= 1'b1;
    for (int i = 0; i < 9 && load_halt !== 1'b1; i++) @(negedge clk);
    chk("flg_h", 2'h3, {wdt_timeout_flag, powerdown_flag});
    @(negedge clk);
    chk("pc_h", 13'h0000, pc);
    chk("ie_h", 8'hA5, int_en);
    hold_n(n);
    chk("sst", 1'b1, n >= w - 1 && n <= w + 1);
    @(posedge clk);
    wdt_overflow <= 1'b0;
    halted <= 1'b0;
  endtask
  task automatic t_lv();
    int n;
    core_wr(8'h5A);
    low_voltage_reset <= 1'b1;
    repeat (3) @(posedge clk);
    low_voltage_reset <= 1'b0;
    repeat (4) @(negedge clk);
    hold_n(n);
    chk("flg_l", 2'h3, {wdt_timeout_flag, powerdown_flag});
    chk("ie_l", 8'h00, int_en);
    @(posedge clk);
    flag_clear <= 1'b1;
    @(posedge clk);
    flag_clear <= 1'b0;
    @(negedge clk);
    chk("flg_c", 2'h0, {wdt_timeout_flag, powerdown_flag});
  endtask
  task automatic t_por();
    int n;
    @(posedge clk);
    {power_on_reset, low_voltage_reset, wdt_overflow} <= 3'h7;
    repeat (6) @(posedge clk);
    chk("wclr_p", 1'b1, wdt_counter_clear);
    {power_on_reset, low_voltage_reset, wdt_overflow} <= 3'h0;
    hold_n(n);
    chk("wclr", 1'b0, wdt_counter_clear);
    chk("hold", 1'b1, n >= PORC);
    chk("flg_p", 2'h0, {wdt_timeout_flag, powerdown_flag});
    chk("img", 40'hFF03555300, {port_init, mode_ctrl_init, lv_sel_init,
      wdt_ctrl_init, timer_ctrl_init});
    chk("core", 19'h000FF, {sp, int_en, port_ctrl});
    chk("an", 5'h1F, analog_input_pins);
    chk("wdt", 1'b1, wdt_run);
  endtask
  // Bounded by far more cycles than the whole sequence needs.
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    int n;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    power_on_reset <= 1'b0;
    hold_n(n);
    t_norm();
    t_halt(2'h0, 16);
    t_halt(2'h1, 1024);
    t_halt(2'h2, 2);
    t_lv();
    t_por();
    finish_test();
  end
endmodule
`default_nettype wire
